/* hdl/dpw_pkg.sv */
// Package with register map, field positions, reset values and timing counts of the driver modulator block.
package dpw_pkg;
  // Register offsets on the internal register port.
  localparam logic [7:0] HS_CTRL_OFFS   = 8'h08;
  localparam logic [7:0] HS_STAT_OFFS   = 8'h0B;
  localparam logic [7:0] MOD_SEL_OFFS   = 8'h1B;
  localparam logic [7:0] MOD_PER_OFFS   = 8'h30;
  localparam logic [7:0] MOD_DUTY_OFFS  = 8'h31;
  // Field positions inside the control, status and select registers.
  localparam int         SRC_EN_LSB     = 4;
  localparam int         DRV_EN_LSB     = 0;
  localparam int         OS_FLAG_LSB    = 4;
  localparam int         OC_FLAG_LSB    = 0;
  localparam int         HS_SEL_LSB     = 4;
  localparam int         HB_SEL_LSB     = 0;
  // Values after reset.
  localparam logic [7:0] HS_CTRL_RST    = 8'h00;
  localparam logic [3:0] OC_FLAG_RST    = 4'h0;
  localparam logic [7:0] MOD_SEL_RST    = 8'h00;
  localparam logic [7:0] MOD_PER_RST    = 8'h00;
  localparam logic [7:0] MOD_DUTY_RST   = 8'h00;
  localparam logic [7:0] RD_UNMAPPED    = 8'h00;
  // Oscillator pre-division ahead of the period-setting divider.
  localparam int         OSC_PREDIV     = 80;
  localparam logic [7:0] CNT_TOP        = 8'hFF;
endpackage : dpw_pkg

/* hdl/dpw_driver_mod.sv */
// Modulator and high-side diagnostic status logic of the power driver block.
// Overview of operation
// R1: Open/short status bits follow live comparator state, read-only, never latched.
// R2: Over-current flag sets on event, clears by writing one; driver off meanwhile.
// R3: Diagnostic source enabled on a driver suppresses that driver's over-current protection.
// R4: Host should not enable a driver while its diagnostic source is on.
// R5: Host decodes status bit together with the source enable bit.
// R6: Host trusts a diagnostic result only with the driver switched off.
// R7: A short on a high-side output raises over-current and sets its flag.
// R8: Period and duty settings both have 8-bit resolution.
// R9: One modulator output drives any subset of eight drivers via select bits.
// R10: After reset duty is zero and modulator output stays low.
// R11: Host starts generation by writing a nonzero duty.
// R12: Duty writable anytime; copied to shadow only when period counter wraps.
// R13: Select bits reset to zero; all zero disables the modulator.
// R14: All settings come from the host through register accesses.
// R15: Counter runs 0..255, stepping at clock over 80 over setting plus one.
// R16: Output rises at zero unless duty zero, falls when counter meets duty.
// R17: Select writes ignored while modulation runs; select clears on low-power entry.
// R18: Driver and source enables clear on over-temperature; driver enables on low-power entry.
// R19: Driver on is enable gated by modulator when selected, else plain enable.
// R20: Over-current flags read zero after reset; writing zero has no effect.
`timescale 1ns/1ps
`default_nettype none

module dpw_driver_mod
  import dpw_pkg::*;
#(
  parameter int OSC_DIV = OSC_PREDIV
) (
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic       clkEn,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic      [7:0] regRdData,
  input  wire logic [3:0] diagCompIn,
  input  wire logic [3:0] overCurrentIn,
  input  wire logic       overTempEvent,
  input  wire logic       lowPowerEntry,
  input  wire logic [3:0] hbEnable,
  output logic      [3:0] hsOn,
  output logic      [3:0] hbOn,
  output logic            modOut
);

  // Width of the pre-divider counter.
  localparam int PW = $clog2(OSC_DIV);
  localparam logic [PW-1:0] PRE_TOP = PW'(OSC_DIV - 1);

  // Whole state of the block.
  typedef struct packed {
    logic [3:0]    diagSync1;
    logic [3:0]    diagSync2;
    logic [3:0]    ocSync1;
    logic [3:0]    ocSync2;
    logic [3:0]    srcEn;
    logic [3:0]    drvEn;
    logic [3:0]    ocFlag;
    logic [7:0]    modSel;
    logic [7:0]    perSet;
    logic [7:0]    dutySet;
    logic [7:0]    dutyShadow;
    logic [PW-1:0] preCnt;
    logic [7:0]    divCnt;
    logic [7:0]    perCnt;
    logic          modOut;
    logic [7:0]    rdData;
  } dpw_state_s;

  dpw_state_s st_r;
  dpw_state_s st_nxt;

  // Address match used by both the write and read paths.
  // Sharing it keeps one address map for writes and reads, so the two cannot drift apart.
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] offs);
    return addr == offs;
  endfunction

  logic       modActive;
  logic       modRunning;
  logic       preWrap;
  logic       stepTick;
  logic [7:0] cntNext;
  logic [3:0] ocEvent;
  logic [3:0] hsSel;
  logic [3:0] hbSel;
  logic [7:0] statusByte;

  // Modulator enable, run state and the counter step.
  // The select lockout also looks at the shadow copy, so a host that clears the duty
  // setting must still wait for the current period to end before changing the selects.
  // A step happens only on the last pre-divider count of the last period-setting count.
  always_comb begin
    modActive  = |st_r.modSel; // R13 R9
    modRunning = (st_r.dutySet != MOD_DUTY_RST) || (st_r.dutyShadow != MOD_DUTY_RST);
    preWrap    = st_r.preCnt == PRE_TOP;
    stepTick   = preWrap && (st_r.divCnt == st_r.perSet); // R15
    cntNext    = st_r.perCnt + 8'h01;
    ocEvent    = st_r.ocSync2 & ~st_r.srcEn; // R3 R7
    hsSel      = st_r.modSel[HS_SEL_LSB +: 4];
    hbSel      = st_r.modSel[HB_SEL_LSB +: 4];
    statusByte = {st_r.diagSync2, st_r.ocFlag}; // R1
  end

  // Next-state logic for registers, synchronisers and the modulator.
  always_comb begin
    st_nxt = st_r;

    // Two-flop synchronisers for the analog comparator inputs.
    // Only the second stage is read anywhere, because the first may still be settling.
    st_nxt.diagSync1 = diagCompIn;
    st_nxt.diagSync2 = st_r.diagSync1;
    st_nxt.ocSync1   = overCurrentIn;
    st_nxt.ocSync2   = st_r.ocSync1;

    // Host register writes.
    if (regWrite) begin // R14
      if (hit(regAddr, HS_CTRL_OFFS)) begin
        st_nxt.srcEn = regWrData[SRC_EN_LSB +: 4];
        st_nxt.drvEn = regWrData[DRV_EN_LSB +: 4];
      end
      if (hit(regAddr, HS_STAT_OFFS)) begin
        st_nxt.ocFlag = st_r.ocFlag & ~regWrData[OC_FLAG_LSB +: 4]; // R2 R20
      end
      if (hit(regAddr, MOD_SEL_OFFS) && !modRunning) begin
        st_nxt.modSel = regWrData; // R17
      end
      if (hit(regAddr, MOD_PER_OFFS)) begin
        st_nxt.perSet = regWrData; // R8
      end
      if (hit(regAddr, MOD_DUTY_OFFS)) begin
        st_nxt.dutySet = regWrData; // R8 R12
      end
    end

    // Over-current sets the sticky flag; a set in the clear cycle wins.
    // An enabled diagnostic source masks the event, so a driver under test has no protection.
    st_nxt.ocFlag = st_nxt.ocFlag | ocEvent; // R2 R7

    // Protective clears of the enables.
    // Low-power entry leaves the diagnostic sources alone; software turns them off beforehand.
    if (overTempEvent) begin
      st_nxt.drvEn = 4'h0; // R18
      st_nxt.srcEn = 4'h0; // R18
    end
    if (lowPowerEntry) begin
      st_nxt.drvEn  = 4'h0; // R18
      st_nxt.modSel = MOD_SEL_RST; // R17
    end

    // Period counter with pre-divider and period-setting divider.
    // With no select bit set the counter parks at its top value, so the first step after
    // a select write is a wrap that loads the shadow and decides the first high phase.
    if (!modActive) begin
      st_nxt.preCnt     = '0; // R13
      st_nxt.divCnt     = 8'h00;
      st_nxt.perCnt     = CNT_TOP;
      st_nxt.dutyShadow = MOD_DUTY_RST;
      st_nxt.modOut     = 1'b0;
    end else begin
      st_nxt.preCnt = preWrap ? '0 : st_r.preCnt + PW'(1);
      if (preWrap) begin
        st_nxt.divCnt = stepTick ? 8'h00 : st_r.divCnt + 8'h01; // R15
      end
      if (stepTick) begin
        st_nxt.perCnt = cntNext; // R15
        if (cntNext == 8'h00) begin
          st_nxt.dutyShadow = st_r.dutySet; // R12
          st_nxt.modOut     = st_r.dutySet != 8'h00; // R16 R10
        end else if (cntNext == st_r.dutyShadow) begin
          st_nxt.modOut = 1'b0; // R16
        end
      end
    end

    // Registered read data, which holds until the next read.
    // Unmapped offsets read as zero so a stray host access cannot expose stale values.
    if (regRead) begin
      unique case (1'b1)
        hit(regAddr, HS_CTRL_OFFS):  st_nxt.rdData = {st_r.srcEn, st_r.drvEn};
        hit(regAddr, HS_STAT_OFFS):  st_nxt.rdData = statusByte; // R1 R20
        hit(regAddr, MOD_SEL_OFFS):  st_nxt.rdData = st_r.modSel;
        hit(regAddr, MOD_PER_OFFS):  st_nxt.rdData = st_r.perSet;
        hit(regAddr, MOD_DUTY_OFFS): st_nxt.rdData = st_r.dutySet;
        default:                     st_nxt.rdData = RD_UNMAPPED;
      endcase
    end
  end

  // State register, frozen while the clock enable is low.
  // The reset branch loads package constants only, so no live state leaks into reset.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_r            <= '0;
      st_r.srcEn      <= HS_CTRL_RST[SRC_EN_LSB +: 4];
      st_r.drvEn      <= HS_CTRL_RST[DRV_EN_LSB +: 4];
      st_r.ocFlag     <= OC_FLAG_RST; // R20
      st_r.modSel     <= MOD_SEL_RST; // R13
      st_r.perSet     <= MOD_PER_RST;
      st_r.dutySet    <= MOD_DUTY_RST; // R10
      st_r.dutyShadow <= MOD_DUTY_RST;
      st_r.perCnt     <= CNT_TOP;
      st_r.rdData     <= RD_UNMAPPED;
    end else if (clkEn) begin
      st_r <= st_nxt;
    end
  end

  // Driver gating; an over-current flag holds its driver off.
  // The half-bridge enables come from logic on this clock, so they are gated directly
  // without a synchroniser; every other term comes straight from flops.
  always_comb begin
    hsOn      = st_r.drvEn & ~st_r.ocFlag & (~hsSel | {4{st_r.modOut}}); // R19 R2 R9
    hbOn      = hbEnable & (~hbSel | {4{st_r.modOut}}); // R19 R9
    modOut    = st_r.modOut;
    regRdData = st_r.rdData;
  end

endmodule // dpw_driver_mod

`default_nettype wire

/* verification/dpw_host_model.sv */
// Host model that issues register writes and reads to the block.
`timescale 1ns/1ps
`default_nettype none
module dpw_host_model (
  input  wire logic       clock,
  input  wire logic [7:0] regRdData,
  output logic      [7:0] regAddr,
  output logic      [7:0] regWrData,
  output logic            regWrite,
  output logic            regRead
);
  initial {regAddr, regWrData, regWrite, regRead} = 18'h0;
  // One strobe cycle per access; released address and data lines show the inverse value, strobes return to zero.
  task automatic xfer(input logic [7:0] a, d, input logic w, output logic [7:0] q);
    @(negedge clock);
    {regAddr, regWrData, regWrite, regRead} = {a, d, w, !w};
    @(negedge clock);
    {regAddr, regWrData, regWrite, regRead} = {~a, ~d, 2'h0};
    q = regRdData;
  endtask
endmodule // dpw_host_model
`default_nettype wire

/* verification/dpw_driver_mod_props.sv */
// Port checker of the driver modulator block.
`timescale 1ns/1ps
`default_nettype none
module dpw_driver_mod_props
  import dpw_pkg::*;
(
  input wire logic       clock,
  input wire logic       arst_n,
  input wire logic       clkEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regRdData,
  input wire logic [3:0] diagCompIn,
  input wire logic [3:0] overCurrentIn,
  input wire logic       overTempEvent,
  input wire logic       lowPowerEntry,
  input wire logic [3:0] hbEnable,
  input wire logic [3:0] hsOn,
  input wire logic [3:0] hbOn,
  input wire logic       modOut
);
  logic [3:0] srcEn_r;
  // Mirror of the diagnostic source enables, cleared by over-temperature.
  always_ff @(posedge clock or negedge arst_n)
    if (!arst_n) srcEn_r <= 4'h0;
    else if (clkEn && overTempEvent) srcEn_r <= 4'h0;
    else if (clkEn && regWrite && regAddr == HS_CTRL_OFFS) srcEn_r <= regWrData[7:4];
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  property p_rst; $rose(arst_n) |-> regRdData == 8'h00 && !modOut && hsOn == 4'h0; endproperty
  a_rst: assert property (p_rst) else $error("reset values");
  property p_stand; !(clkEn && regRead) |=> $stable(regRdData); endproperty
  a_stand: assert property (p_stand) else $error("read data moved");
  property p_unmap; clkEn && regRead && regAddr == 8'h55 |=> regRdData == RD_UNMAPPED; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_diag; (clkEn && $stable(diagCompIn))[*3] ##0 (regRead && regAddr == HS_STAT_OFFS)
    |=> regRdData[7:4] == $past(diagCompIn); endproperty
  a_diag: assert property (p_diag) else $error("live status");
  property p_oc; (clkEn && overCurrentIn[0] && !srcEn_r[0])[*3] |=> !hsOn[0]; endproperty
  a_oc: assert property (p_oc) else $error("over-current");
  property p_hb; (hbOn & ~hbEnable) == 4'h0; endproperty
  a_hb: assert property (p_hb) else $error("half-bridge gate");
  property p_off; clkEn && (lowPowerEntry || overTempEvent) |=> hsOn == 4'h0; endproperty
  a_off: assert property (p_off) else $error("driver not off");
  property p_step; $changed(modOut) |=> ($stable(modOut) || $past(lowPowerEntry))[*3]; endproperty
  a_step: assert property (p_step) else $error("step rate");
endmodule // dpw_driver_mod_props
bind dpw_driver_mod dpw_driver_mod_props chk_i (
  .clock         (clock),
  .arst_n        (arst_n),
  .clkEn         (clkEn),
  .regAddr       (regAddr),
  .regWrData     (regWrData),
  .regWrite      (regWrite),
  .regRead       (regRead),
  .regRdData     (regRdData),
  .diagCompIn    (diagCompIn),
  .overCurrentIn (overCurrentIn),
  .overTempEvent (overTempEvent),
  .lowPowerEntry (lowPowerEntry),
  .hbEnable      (hbEnable),
  .hsOn          (hsOn),
  .hbOn          (hbOn),
  .modOut        (modOut)
);
`default_nettype wire

/* verification/dpw_driver_mod_tb.sv */
// Self-checking bench of the driver modulator block.
`timescale 1ns/1ps
`default_nettype none
module dpw_driver_mod_tb import dpw_pkg::*;;
  logic       clock = 1'h0, arst_n = 1'h0, clkEn = 1'h1, overTempEvent = 1'h0, lowPowerEntry = 1'h0;
  logic       regWrite, regRead, modOut;
  logic [7:0] regAddr, regWrData, regRdData, q;
  logic [3:0] diagCompIn = 4'h0, overCurrentIn = 4'h0, hbEnable = 4'hF, hsOn, hbOn;
  int         fail_count = 0, n_checks = 0, hi, bad;
  logic [23:0] rows [4] = '{24'h083C3C, 24'h31FFFF, 24'h55AA00, 24'h0BF000};
  // Clock of 100 ns period.
  always #50 clock = ~clock;
  dpw_driver_mod #(.OSC_DIV(4)) uut (
    .clock         (clock),
    .arst_n        (arst_n),
    .clkEn         (clkEn),
    .regAddr       (regAddr),
    .regWrData     (regWrData),
    .regWrite      (regWrite),
    .regRead       (regRead),
    .regRdData     (regRdData),
    .diagCompIn    (diagCompIn),
    .overCurrentIn (overCurrentIn),
    .overTempEvent (overTempEvent),
    .lowPowerEntry (lowPowerEntry),
    .hbEnable      (hbEnable),
    .hsOn          (hsOn),
    .hbOn          (hbOn),
    .modOut        (modOut)
  );
  dpw_host_model h (
    .clock     (clock),
    .regRdData (regRdData),
    .regAddr   (regAddr),
    .regWrData (regWrData),
    .regWrite  (regWrite),
    .regRead   (regRead)
  );
  task automatic chk(input logic [7:0] s, e);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("Error %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, d); h.xfer(a, d, 1'h1, q); endtask
  task automatic rd(input logic [7:0] a, e); h.xfer(a, 8'h00, 1'h0, q); chk(q, e); endtask
  task automatic pulse(ref logic s); s = 1'h1; @(negedge clock); s = 1'h0; endtask
  // Counts modulator high cycles and driver mismatches over one period.
  task automatic run(output int hi, bad);
    hi = 0;
    bad = 0;
    repeat (1024) begin
      @(negedge clock);
      hi += modOut;
      bad += int'(hsOn[0] !== modOut) + int'(hbOn[0] !== modOut) + int'(hbOn[3:1] !== 3'h7);
    end
  endtask
  task automatic results;
    if (fail_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Reset, register table, then diagnostics and modulation.
  initial begin
    repeat (6) @(negedge clock);
    arst_n = 1'h1;
    chk({3'h0, modOut, hsOn}, 8'h00);
    chk(regRdData, 8'h00);
    chk(hbOn, hbEnable);
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rows[i][7:0]);
    end
    chk(modOut, 1'h0);
    diagCompIn = 4'hA;
    wr(HS_CTRL_OFFS, 8'h21);
    overCurrentIn = 4'h3;
    repeat (5) @(negedge clock);
    chk(hsOn, 4'h0);
    overCurrentIn = 4'h0;
    wr(HS_STAT_OFFS, 8'h00);
    // Second driver reads open load, fourth a short to supply.
    rd(HS_STAT_OFFS, 8'hA1);
    wr(HS_STAT_OFFS, 8'h01);
    rd(HS_STAT_OFFS, 8'hA0);
    pulse(overTempEvent);
    rd(HS_CTRL_OFFS, 8'h00);
    // The duty setting from the table is still nonzero, so this select write is refused.
    wr(MOD_SEL_OFFS, 8'h11);
    rd(MOD_SEL_OFFS, 8'h00);
    wr(MOD_DUTY_OFFS, 8'h00);
    wr(MOD_SEL_OFFS, 8'h11);
    wr(HS_CTRL_OFFS, 8'h01);
    wr(MOD_PER_OFFS, 8'h00);
    wr(MOD_DUTY_OFFS, 8'h02);
    wr(MOD_SEL_OFFS, 8'h01);
    rd(MOD_SEL_OFFS, 8'h11);
    run(hi, bad);
    run(hi, bad);
    chk(8'(hi), 8'h08);
    chk(8'(bad != 0), 8'h00);
    wr(MOD_DUTY_OFFS, 8'h00);
    run(hi, bad);
    run(hi, bad);
    chk(8'(hi), 8'h00);
    pulse(lowPowerEntry);
    rd(MOD_SEL_OFFS, 8'h00);
    chk(hsOn, 4'h0);
    // A write while the clock enable is low must leave the state untouched.
    clkEn = 1'h0;
    wr(HS_CTRL_OFFS, 8'h0F);
    clkEn = 1'h1;
    rd(HS_CTRL_OFFS, 8'h00);
    // Reset in mid-run clears the duty setting and the read data.
    wr(MOD_DUTY_OFFS, 8'h40);
    rd(MOD_DUTY_OFFS, 8'h40);
    arst_n = 1'h0;
    @(negedge clock);
    chk({3'h0, modOut, hsOn}, 8'h00);
    chk(regRdData, 8'h00);
    arst_n = 1'h1;
    rd(MOD_DUTY_OFFS, 8'h00);
    results();
  end
endmodule // dpw_driver_mod_tb
`default_nettype wire
